// file: core/asc_sram_host.sv
// Host controller that drives a 32Kx8 asynchronous SRAM through its pins.
// Functional notes
// - Host holds write data 30 ns before and 0 ns after write end.
// - Address setup 60 ns, select 60 ns, strobe 50 ns, writes 70 ns apart.
// - Read cycles last 70 ns; data valid 70 ns after address change.
// - Strobe-ended write with output enable low lasts turn-off plus data setup.
// - Host never drives data while the device drives it.
// - Address valid before or with select falling for a read.
`timescale 1ns/1ps
module asc_sram_host (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Request port
  input  wire logic                      reqValid,
  input  wire logic                      reqWrite,
  input  wire logic [asc_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [asc_pkg::DATA_W-1:0] reqData,
  output logic                           reqReady,
  // Answer port
  output logic                           rspValid,
  output logic [asc_pkg::DATA_W-1:0]     rspData,
  // SRAM pins
  output logic [asc_pkg::ADDR_W-1:0]     sramAddr,
  output logic                           sramSelect_n,
  output logic                           sramOutEnable_n,
  output logic                           sramWrite_n,
  input  wire logic [asc_pkg::DATA_W-1:0] sramDataIn,
  output logic [asc_pkg::DATA_W-1:0]     sramDataOut,
  output logic                           sramDataOe_n
);
  typedef struct packed {
    asc_pkg::asc_state_e             state;
    logic                            ready;
    logic                            rspValid;
    logic [asc_pkg::DATA_W-1:0]      rspData;
    logic [asc_pkg::ADDR_W-1:0]      addr;
    logic                            sel_n;
    logic                            oe_n;
    logic                            we_n;
    logic [asc_pkg::DATA_W-1:0]      dout;
    logic                            doe_n;
  } asc_regs_s;

  // Idle pins, an empty answer and a ready port: the state after reset, and also the
  // state that an illegal code falls back to, so a corrupted sequencer cannot hang.
  localparam asc_regs_s RESET_REGS = '{
    state:    asc_pkg::ST_IDLE,
    ready:    1'b1,
    rspValid: 1'b0,
    rspData:  8'h00,
    addr:     15'h0000,
    sel_n:    1'b1,
    oe_n:     1'b1,
    we_n:     1'b1,
    dout:     8'h00,
    doe_n:    1'b1
  };

  asc_regs_s cur;
  asc_regs_s next_cur;
  logic      tLoad;
  logic [asc_pkg::CNT_W-1:0] tValue;
  logic      tDone;
  logic      takeReq;

  // A request counts only on an edge where the port shows ready; all others are ignored.
  assign takeReq = reqValid && cur.ready;

  // One timer serves every phase except ST_WEND, which lasts one clock; only the state entered on the load looks at done.
  asc_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (tLoad),
    .value   (tValue),
    .done    (tDone)
  );

  // Cycle plan, 40 ns a clock, edges counted from the one that takes the request.
  // Read: edge 0 puts out the address and lowers select and output enable together;
  // edge 2 samples the data lines, 80 ns after all three changed, and raises select
  // and output enable; edge 4 shows the port ready again.
  // Write: edge 0 puts out address and data, lowers select and starts driving the
  // data lines with output enable high; edge 1 lowers the strobe; edge 3 raises it,
  // ending the write with data and address still standing; edge 4 raises select and
  // releases the data lines; edge 6 shows the port ready again.
  // The idle clocks after each access give the device time to turn its drivers off
  // and to power down, and keep two accesses at least 70 ns apart.
  // Trade-off: five clocks a read and seven a write with no overlap of requests; the
  // pin timing is then the same whatever the request pattern, at a cost in throughput.
  // Limitation: the counts assume a 40 ns clock; a faster clock needs larger counts.
  always_comb begin
    next_cur          = cur;
    next_cur.rspValid = 1'b0;
    tLoad             = 1'b0;
    tValue            = asc_pkg::READ_CNT;
    unique case (cur.state)
      asc_pkg::ST_IDLE: begin
        if (takeReq) begin
          next_cur.ready = 1'b0;
          next_cur.addr  = reqAddr;
          next_cur.sel_n = 1'b0;
          tLoad          = 1'b1;
          if (reqWrite) begin
            // Output enable stays high so the device never drives during the write.
            next_cur.oe_n  = 1'b1;
            next_cur.dout  = reqData;
            next_cur.doe_n = 1'b0;
            tValue         = asc_pkg::TURN_CNT;
            next_cur.state = asc_pkg::ST_WSET;
          end else begin
            // Address, select and output enable change on one edge, so no address is late.
            next_cur.oe_n  = 1'b0;
            next_cur.doe_n = 1'b1;
            tValue         = asc_pkg::READ_CNT;
            next_cur.state = asc_pkg::ST_RD;
          end
        end
      end

      asc_pkg::ST_RD: begin
        // Data is sampled on the edge that also deselects, so it is taken while driven.
        if (tDone) begin
          next_cur.rspData  = sramDataIn;
          next_cur.rspValid = 1'b1;
          next_cur.sel_n    = 1'b1;
          next_cur.oe_n     = 1'b1;
          tLoad             = 1'b1;
          tValue            = asc_pkg::GAP_CNT;
          next_cur.state    = asc_pkg::ST_GAP;
        end
      end

      asc_pkg::ST_WSET: begin
        // Select, address and data settle a clock before the strobe falls.
        if (tDone) begin
          next_cur.we_n  = 1'b0;
          tLoad          = 1'b1;
          tValue         = asc_pkg::WRITE_CNT;
          next_cur.state = asc_pkg::ST_WPULSE;
        end
      end

      asc_pkg::ST_WPULSE: begin
        if (tDone) begin
          // Strobe ends the write; data and address stay one more cycle as hold.
          next_cur.we_n  = 1'b1;
          next_cur.state = asc_pkg::ST_WEND;
        end
      end

      asc_pkg::ST_WEND: begin
        // Select rises a clock after the strobe, so the strobe alone ends the write.
        next_cur.sel_n = 1'b1;
        next_cur.doe_n = 1'b1;
        tLoad          = 1'b1;
        tValue         = asc_pkg::GAP_CNT;
        next_cur.state = asc_pkg::ST_GAP;
      end

      asc_pkg::ST_GAP: begin
        // Deselected idle time lets the device turn off before the next access.
        if (tDone) begin
          next_cur.ready = 1'b1;
          next_cur.state = asc_pkg::ST_IDLE;
        end
      end

      default: begin
        // A code outside the enumeration: drop the access and return to idle.
        next_cur = RESET_REGS;
      end
    endcase

    // Last-word guards: whatever a state asks for, the host never drives the data lines
    // while the device may, and no strobe or output enable stays low once deselected.
    if (!next_cur.doe_n) begin
      next_cur.oe_n = 1'b1;
    end
    if (next_cur.sel_n) begin
      next_cur.we_n = 1'b1;
      next_cur.oe_n = 1'b1;
    end

    // A read never has the host driving, whatever an earlier state left behind.
    if (next_cur.state == asc_pkg::ST_RD) begin
      next_cur.doe_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= RESET_REGS;
    end else begin
      cur <= next_cur;
    end
  end

  // Every pin comes straight from a register: a glitch on the strobe while the
  // device is selected would be a stray write.
  assign reqReady        = cur.ready;
  assign rspValid        = cur.rspValid;
  assign rspData         = cur.rspData;
  assign sramAddr        = cur.addr;
  assign sramSelect_n    = cur.sel_n;
  assign sramOutEnable_n = cur.oe_n;
  assign sramWrite_n     = cur.we_n;
  assign sramDataOut     = cur.dout;
  assign sramDataOe_n    = cur.doe_n;
endmodule // asc_sram_host

// file: core/asc_timer.sv
// Down-counter that times each phase of a bus cycle.
`timescale 1ns/1ps
module asc_timer (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Control
  input  wire logic                     load,
  input  wire logic [asc_pkg::CNT_W-1:0] value,
  // Status
  output logic                          done
);
  typedef struct packed {
    logic [asc_pkg::CNT_W-1:0] count;
  } asc_timer_s;

  asc_timer_s cur;
  asc_timer_s next_cur;

  always_comb begin
    next_cur = cur;
    if (load) begin
      next_cur.count = value;
    end else if (cur.count != 3'h0) begin
      next_cur.count = cur.count - 3'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '{count: 3'h0};
    end else begin
      cur <= next_cur;
    end
  end

  // Done is high on the last cycle of the loaded span.
  assign done = (cur.count == 3'h1) || (cur.count == 3'h0 && !load);
endmodule // asc_timer

// file: inc/asc_pkg.sv
// Package of timing constants, widths and state enumeration for the SRAM host controller.
package asc_pkg;
  localparam int unsigned ADDR_W    = 15;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned CLK_NS    = 40;
  // Device timings in ns.
  localparam int unsigned READ_CYCLE_MIN_NS          = 70;
  localparam int unsigned ADDRESS_ACCESS_MAX_NS      = 70;
  localparam int unsigned SELECT_ACCESS_MAX_NS       = 70;
  localparam int unsigned OUTPUT_ENABLE_ACCESS_MAX_NS = 35;
  localparam int unsigned WRITE_CYCLE_MIN_NS         = 70;
  localparam int unsigned SELECT_TO_WRITE_END_NS     = 60;
  localparam int unsigned ADDRESS_SETUP_TO_WRITE_END_NS = 60;
  localparam int unsigned WRITE_PULSE_MIN_NS         = 50;
  localparam int unsigned WRITE_DATA_SETUP_NS        = 30;
  localparam int unsigned WRITE_TURNOFF_DELAY_NS     = 25;
  localparam int unsigned POWERDOWN_DELAY_NS         = 70;
  // Cycle counts; minimum times round up.
  localparam int unsigned READ_CYC  = (SELECT_ACCESS_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE_CYC = (SELECT_TO_WRITE_END_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TURN_CYC  = (WRITE_TURNOFF_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC   = (POWERDOWN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W     = 3;
  localparam logic [CNT_W-1:0] READ_CNT  = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
  localparam logic [CNT_W-1:0] TURN_CNT  = CNT_W'(TURN_CYC);
  localparam logic [CNT_W-1:0] GAP_CNT   = CNT_W'(GAP_CYC);
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WSET, ST_WPULSE, ST_WEND, ST_GAP} asc_state_e;
endpackage

// file: testbench/asc_sram_host_assertions.sv
// Checker of the host pin sequences and the answer port.
`timescale 1ns/1ps
module asc_sram_host_assertions (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       sys_rst,
  // Request and answer
  input wire logic                       reqValid,
  input wire logic                       reqWrite,
  input wire logic                       reqReady,
  input wire logic                       rspValid,
  input wire logic [asc_pkg::DATA_W-1:0] rspData,
  // SRAM pins
  input wire logic [asc_pkg::ADDR_W-1:0] sramAddr,
  input wire logic                       sramSelect_n,
  input wire logic                       sramOutEnable_n,
  input wire logic                       sramWrite_n,
  input wire logic [asc_pkg::DATA_W-1:0] sramDataIn,
  input wire logic [asc_pkg::DATA_W-1:0] sramDataOut,
  input wire logic                       sramDataOe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence takeRd; reqValid && reqReady && !reqWrite; endsequence
  sequence takeWr; reqValid && reqReady && reqWrite; endsequence
  rd_walk_a: assert property (takeRd |=> (!sramSelect_n && !sramOutEnable_n) [*2] ##1
    (rspValid && sramSelect_n)) else $error("read walk");
  rd_data_a: assert property (rspValid |-> rspData == $past(sramDataIn)) else $error("rd data");
  wr_walk_a: assert property (takeWr |=> (!sramSelect_n && sramWrite_n) ##1
    (!sramSelect_n && !sramWrite_n) [*2] ##1 (!sramSelect_n && sramWrite_n) ##1 sramSelect_n)
    else $error("write walk");
  wr_data_a: assert property ($rose(sramWrite_n) |-> !sramDataOe_n &&
    sramDataOut == $past(sramDataOut, 3)) else $error("wr data");
  no_fight_a: assert property (!sramDataOe_n |-> sramOutEnable_n && !sramSelect_n)
    else $error("bus fight");
  addr_hold_a: assert property (!sramSelect_n && !$fell(sramSelect_n) |-> $stable(sramAddr))
    else $error("addr moved");
  sel_gap_a: assert property ($rose(sramSelect_n) |-> sramSelect_n [*3]) else $error("gap");
  busy_hold_a: assert property (reqValid && reqReady |=> !reqReady [*4]) else $error("ready");
  wr_oe_high_a: assert property (!sramWrite_n |-> sramOutEnable_n)
    else $error("oe low in write");
endmodule // asc_sram_host_assertions
bind asc_sram_host asc_sram_host_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
  .reqValid(reqValid), .reqWrite(reqWrite), .reqReady(reqReady), .rspValid(rspValid),
  .rspData(rspData), .sramAddr(sramAddr), .sramSelect_n(sramSelect_n),
  .sramOutEnable_n(sramOutEnable_n), .sramWrite_n(sramWrite_n), .sramDataIn(sramDataIn),
  .sramDataOut(sramDataOut), .sramDataOe_n(sramDataOe_n));

// file: testbench/asc_sram_model.sv
// Behavioural 32Kx8 asynchronous SRAM facing the host pins.
`timescale 1ns/1ps
module asc_sram_model #(
  parameter int ACC_NS = 10
) (
  // Memory pins
  input  wire logic [asc_pkg::ADDR_W-1:0] addr,
  input  wire logic                       select_n,
  input  wire logic                       outEnable_n,
  input  wire logic                       write_n,
  // Data bus
  input  wire logic [asc_pkg::DATA_W-1:0] hostData,
  input  wire logic                       hostOe_n,
  output logic      [asc_pkg::DATA_W-1:0] pinData
);
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'h00;
  logic [7:0] rd;
  wire        drive = !select_n && !outEnable_n && write_n;
  wire        inWrite = !select_n && !write_n;
  // A slow access path shows whether the host waits long enough.
  assign #(ACC_NS) rd = mem[addr];
  // Released lines show the inverse of the last value, never a held copy.
  assign pinData = !hostOe_n ? hostData : (drive ? rd : ~last);
  always @(negedge inWrite) mem[addr] = pinData;
  // One process remembers whatever was last driven, by either side.
  always @(pinData) begin
    if (!hostOe_n || drive) begin
      last = pinData;
    end
  end
endmodule // asc_sram_model

// file: testbench/testbench.sv
// Self-checking bench of the SRAM host driving a behavioural memory.
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reqValid = 1'b0;
  logic       reqWrite = 1'b0;
  logic [14:0] reqAddr = 15'h0000;
  logic [7:0] reqData = 8'h00;
  logic       reqReady, rspValid, sramSelect_n, sramOutEnable_n, sramWrite_n, sramDataOe_n;
  logic [7:0] rspData, sramDataIn, sramDataOut, q;
  logic [14:0] sramAddr;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  always #20 clk = ~clk;
  asc_sram_host u_asc_sram_host (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .sramAddr(sramAddr), .sramSelect_n(sramSelect_n),
    .sramOutEnable_n(sramOutEnable_n), .sramWrite_n(sramWrite_n), .sramDataIn(sramDataIn),
    .sramDataOut(sramDataOut), .sramDataOe_n(sramDataOe_n));
  asc_sram_model #(.ACC_NS(65)) u_asc_sram_model (.addr(sramAddr), .select_n(sramSelect_n),
    .outEnable_n(sramOutEnable_n), .write_n(sramWrite_n), .hostData(sramDataOut),
    .hostOe_n(sramDataOe_n), .pinData(sramDataIn));
  task close_out();
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for ready, offers one request for a single edge, then collects a read answer.
  task req(input logic w, input logic [14:0] a, input logic [7:0] d, output logic [7:0] r);
    int i;
    i = 0;
    while (reqReady !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    @(negedge clk);
    reqValid = 1'b0;
    r = 8'h00;
    for (i = 0; i < 8 && !w && rspValid !== 1'b1; i++) @(negedge clk);
    if (!w) r = (rspValid === 1'b1) ? rspData : 8'hxx;
  endtask
  task t_edges();
    logic [14:0] a [3];
    logic [7:0] d [3];
    a = '{15'h0000, 15'h7fff, 15'h4000};
    d = '{8'ha5, 8'h5a, 8'h3c};
    for (int i = 0; i < 3; i++) req(1'b1, a[i], d[i], q);
    for (int i = 0; i < 3; i++) begin
      req(1'b0, a[i], 8'h00, q);
      check(q, d[i]);
    end
  endtask
  // A request offered while busy must leave memory untouched.
  task t_refuse();
    req(1'b1, 15'h0002, 8'h11, q);
    req(1'b1, 15'h0001, 8'hc3, q);
    @(negedge clk);
    reqValid = 1'b1;
    reqData = 8'hee;
    reqAddr = 15'h0002;
    @(negedge clk);
    reqValid = 1'b0;
    req(1'b0, 15'h0002, 8'h00, q);
    check(q, 8'h11);
    req(1'b0, 15'h0001, 8'h00, q);
    check(q, 8'hc3);
  endtask
  task t_midreset();
    repeat (3) @(negedge clk);
    reqValid = 1'b1;
    reqWrite = 1'b0;
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    sys_rst = 1'b1;
    #1;
    check({4'h0, reqReady, rspValid, sramSelect_n, sramDataOe_n}, 8'h0b);
    @(negedge clk);
    sys_rst = 1'b0;
    req(1'b0, 15'h7fff, 8'h00, q);
    check(q, 8'h5a);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    t_edges();
    t_refuse();
    t_midreset();
    close_out();
  end
endmodule // testbench
